// ---- include/logger_mem_regs.vh ----
// address map, field positions and constants of the password-gated logger memory
`ifndef LOGGER_MEM_REGS_VH
`define LOGGER_MEM_REGS_VH
`define ADDR_W 16
`define A_GEN_STATUS 16'h0215
`define A_MISSION_CTRL 16'h0213
`define A_LIFE_CNT0 16'h0223
`define A_LIFE_CNT1 16'h0224
`define A_LIFE_CNT2 16'h0225
`define A_VARIANT 16'h0226
`define A_PW_CTRL 16'h0227
`define A_READ_SECRET 16'h0228
`define A_FULL_SECRET 16'h0230
`define A_SECRET_END 16'h0237
`define BIT_MISSION_RUN 1
`define BIT_ROLLOVER 1
`define BIT_FMT16 2
`define PW_ENABLE_PATTERN 8'hAA
`define PW_CTRL_RESET 8'h00
`define GEN_STATUS_FIXED 8'hC0
`define LIFE_CNT_MAX 24'hFFFFFF
`define SECRET_BITS 7'h40
`define LOG_BYTES 14'h2000
`define LOG_ADDR_W 13
`define LOG_PAGE 3'h1
`define LOG_IDX_W 14
`define LOG_LAST8 13'h1FFF
`define LOG_LAST16 13'h0FFF
`define CMD_RD_CRC 3'h1
`define CMD_COPY_SP 3'h2
`define CMD_CLEAR 3'h3
`define CMD_START 3'h4
`define CMD_STOP 3'h5
`define CMD_SP_RW 3'h6
`define CMD_FORCE_CONV 3'h7
`define VARIANT_CODE_DEF 8'h5A
`endif

// ---- design/secret_shift.v ----
// serial collector of the 64-bit password slot, bit 0 first
`default_nettype none
`include "logger_mem_regs.vh"
module secret_shift (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_clear,
    input wire i_bit_valid,
    input wire i_bit,
    output wire [63:0] o_value,
    output wire o_complete
);
    reg [63:0] shift_ff; // collected bits, first bit ends in bit 0
    reg [6:0] count_ff; // bits received so far
    // shift right so the first bit lands at position 0
    always @(posedge i_clk) begin
        if (i_sys_rst || (i_ce && i_clear)) begin
            shift_ff <= 64'h0000000000000000;
            count_ff <= 7'h00;
        end else if (i_ce && i_bit_valid && count_ff != `SECRET_BITS) begin
            shift_ff <= {i_bit, shift_ff[63:1]};
            count_ff <= count_ff + 7'h01;
        end
    end
    assign o_value = shift_ff;
    // exactly 64 bits fill the slot
    assign o_complete = (count_ff == `SECRET_BITS);
endmodule // secret_shift
`default_nettype wire

// ---- design/datalog_place.v ----
// datalog entry address generator with optional rollover
`default_nettype none
`include "logger_mem_regs.vh"
module datalog_place (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_restart,
    input wire i_step,
    input wire i_fmt16,
    input wire i_rollover,
    output wire [`LOG_ADDR_W-1:0] o_entry,
    output wire o_full_stop
);
    reg [`LOG_ADDR_W-1:0] entry_ff; // next entry index
    reg stop_ff; // area full and rollover off
    wire [`LOG_ADDR_W-1:0] last_w;
    assign last_w = i_fmt16 ? `LOG_LAST16 : `LOG_LAST8;
    // advance one entry per stored sample
    always @(posedge i_clk) begin
        if (i_sys_rst || (i_ce && i_restart)) begin
            entry_ff <= {`LOG_ADDR_W{1'b0}};
            stop_ff <= 1'b0;
        end else if (i_ce && i_step && !stop_ff) begin
            if (entry_ff == last_w) begin
                entry_ff <= {`LOG_ADDR_W{1'b0}};
                stop_ff <= !i_rollover;
            end else begin
                entry_ff <= entry_ff + 1'b1;
            end
        end
    end
    assign o_entry = entry_ff;
    assign o_full_stop = stop_ff;
endmodule // datalog_place
`default_nettype wire

// ---- design/password_gated_logger_memory.v ----
// password gate, protected registers and datalog memory of the logger
// Behaviour
// - 24-bit read-only lifetime count, low byte first
// - read-only variant byte, writes ignored
// - scratchpad and forced conversion need no password
// - checking only when control byte is AAh
// - disabled: any password, still exactly 64 bits
// - enabled: changes need correct full password
// - control byte read-only during mission
// - password locations read back as zero
// - passwords unchanged while mission runs
// - read password gates only CRC read
// - full password gates five commands
// - mission samples stored entry after entry
// - 8192 byte entries or 4096 word entries
// - 16-bit entry upper byte at lower address
// - full: stop, or roll over to start
// - mission flag reads 1 while mission active
// - rollover bit lives in mission control byte
// - count increments per mission wake or conversion
`default_nettype none
`include "logger_mem_regs.vh"
module password_gated_logger_memory #(
    parameter [7:0] VARIANT_CODE = `VARIANT_CODE_DEF // arbitrary value
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_bus_reset,
    input wire i_cmd_valid,
    input wire [2:0] i_cmd,
    input wire i_pw_bit_valid,
    input wire i_pw_bit,
    input wire i_rd_en,
    input wire [`ADDR_W-1:0] i_rd_addr,
    input wire i_copy_en,
    input wire [`ADDR_W-1:0] i_copy_addr,
    input wire [7:0] i_copy_data,
    input wire i_sample_valid,
    input wire i_sample_mission,
    input wire [15:0] i_sample,
    output reg [7:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_granted,
    output reg o_refused,
    output reg o_exec_pulse,
    output reg [2:0] o_exec_cmd,
    output reg o_mission_running_flag,
    output reg o_log_stopped
);
    // one-hot states of the command gate
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_PASS = 4'b0010;
    localparam [3:0] ST_OPEN = 4'b0100;
    localparam [3:0] ST_LOCK = 4'b1000;

    reg [3:0] state_ff; // gate state
    reg [3:0] nxt_state;
    reg [2:0] cmd_ff; // command being gated
    reg [23:0] life_cnt_ff; // lifetime samples
    reg [7:0] pw_ctrl_ff; // password check control byte
    reg [63:0] read_secret_ff; // read access password
    reg [63:0] full_secret_ff; // full access password
    reg [7:0] mission_ctrl_ff; // rollover and format bits
    reg rd_gate_ff; // reads of registers and datalog allowed
    reg [7:0] log_mem [0:`LOG_BYTES-1]; // datalog area
    reg [7:0] rd_byte; // combinational read mux
    reg fmt16_ff; // format latched at mission start

    wire [63:0] pw_value;
    wire pw_complete;
    wire [`LOG_ADDR_W-1:0] entry_w;
    wire log_full_w;
    wire check_on;
    wire read_match;
    wire full_match;
    wire store_w;
    wire [`LOG_ADDR_W-1:0] byte_addr_w;

    // true when the command needs the password slot
    function needs_pw;
        input [2:0] c;
        begin
            needs_pw = (c != `CMD_SP_RW) && (c != `CMD_FORCE_CONV);
        end
    endfunction

    // true when an address falls inside a byte range
    function in_range;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] lo;
        input [`ADDR_W-1:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // password bits collected after the command byte
    secret_shift u_shift (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_clear(state_ff != ST_PASS),
        .i_bit_valid(i_pw_bit_valid && state_ff == ST_PASS),
        .i_bit(i_pw_bit),
        .o_value(pw_value),
        .o_complete(pw_complete)
    );

    assign store_w = i_sample_valid && i_sample_mission &&
        o_mission_running_flag && !log_full_w;

    // datalog placement
    datalog_place u_place (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_restart(state_ff == ST_OPEN && cmd_ff == `CMD_START),
        .i_step(store_w),
        .i_fmt16(fmt16_ff),
        .i_rollover(mission_ctrl_ff[`BIT_ROLLOVER]),
        .o_entry(entry_w),
        .o_full_stop(log_full_w)
    );

    assign check_on = (pw_ctrl_ff == `PW_ENABLE_PATTERN);
    assign read_match = !check_on || (pw_value == read_secret_ff);
    assign full_match = !check_on || (pw_value == full_secret_ff);

    // command gate next state
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    nxt_state = needs_pw(i_cmd) ? ST_PASS : ST_OPEN;
                end
            end
            ST_PASS: begin
                // 64 bits must arrive before any verdict
                if (pw_complete) begin
                    if (full_match ||
                        (cmd_ff == `CMD_RD_CRC && read_match)) begin
                        nxt_state = ST_OPEN;
                    end else begin
                        nxt_state = ST_LOCK;
                    end
                end
            end
            ST_OPEN: begin
                nxt_state = ST_IDLE;
            end
            ST_LOCK: begin
                nxt_state = ST_LOCK;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (i_bus_reset) begin
            nxt_state = ST_IDLE;
        end
    end

    // gate state register and command latch
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_IDLE;
            cmd_ff <= 3'h0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && i_cmd_valid) begin
                cmd_ff <= i_cmd;
            end
        end
    end

    // execution strobes and status outputs
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_granted <= 1'b0;
            o_refused <= 1'b0;
            o_exec_pulse <= 1'b0;
            o_exec_cmd <= 3'h0;
            rd_gate_ff <= 1'b0;
        end else if (i_ce) begin
            o_exec_pulse <= (nxt_state == ST_OPEN);
            o_exec_cmd <= (state_ff == ST_IDLE) ? i_cmd : cmd_ff;
            o_refused <= (nxt_state == ST_LOCK);
            if (nxt_state == ST_OPEN) begin
                o_granted <= 1'b1;
                // memory read access opens only on crc read grant
                rd_gate_ff <= ((state_ff == ST_IDLE) ? i_cmd : cmd_ff)
                    == `CMD_RD_CRC;
            end else if (nxt_state == ST_IDLE || nxt_state == ST_LOCK) begin
                o_granted <= 1'b0;
                if (nxt_state == ST_LOCK || i_bus_reset) begin
                    rd_gate_ff <= 1'b0;
                end
            end
        end
    end

    // mission flag, lifetime count and protected registers
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mission_running_flag <= 1'b0;
            life_cnt_ff <= 24'h000000;
            pw_ctrl_ff <= `PW_CTRL_RESET;
            read_secret_ff <= 64'h0000000000000000;
            full_secret_ff <= 64'h0000000000000000;
            mission_ctrl_ff <= 8'h00;
            fmt16_ff <= 1'b0;
        end else if (i_ce) begin
            // start and stop only after the gate opens
            if (state_ff == ST_OPEN && cmd_ff == `CMD_START) begin
                o_mission_running_flag <= 1'b1;
                fmt16_ff <= mission_ctrl_ff[`BIT_FMT16];
            end else if (state_ff == ST_OPEN && cmd_ff == `CMD_STOP) begin
                o_mission_running_flag <= 1'b0;
            end
            // count wakes in mission or forced conversions between
            if (i_sample_valid && life_cnt_ff != `LIFE_CNT_MAX &&
                (i_sample_mission ? o_mission_running_flag
                                  : !o_mission_running_flag)) begin
                life_cnt_ff <= life_cnt_ff + 24'h000001;
            end
            // copy path from an authorised scratchpad copy
            if (i_copy_en && state_ff == ST_OPEN &&
                cmd_ff == `CMD_COPY_SP) begin
                if (i_copy_addr == `A_MISSION_CTRL &&
                    !o_mission_running_flag) begin
                    mission_ctrl_ff <= i_copy_data;
                end
                if (i_copy_addr == `A_PW_CTRL &&
                    !o_mission_running_flag) begin
                    pw_ctrl_ff <= i_copy_data;
                end
                if (!o_mission_running_flag) begin
                    if (in_range(i_copy_addr, `A_READ_SECRET,
                                 `A_FULL_SECRET - 16'h0001)) begin
                        read_secret_ff[{i_copy_addr[2:0], 3'b000} +: 8]
                            <= i_copy_data;
                    end
                    if (in_range(i_copy_addr, `A_FULL_SECRET,
                                 `A_SECRET_END)) begin
                        full_secret_ff[{i_copy_addr[2:0], 3'b000} +: 8]
                            <= i_copy_data;
                    end
                end
                // variant code and lifetime count ignore writes
            end
        end
    end

    // byte address of the current entry, 16-bit entries take two bytes
    assign byte_addr_w = fmt16_ff ? {entry_w[`LOG_ADDR_W-2:0], 1'b0}
                                  : entry_w;

    // datalog store, upper byte first for 16-bit entries
    always @(posedge i_clk) begin
        if (i_ce && store_w) begin
            if (fmt16_ff) begin
                log_mem[byte_addr_w] <= i_sample[15:8];
                log_mem[byte_addr_w + 1'b1] <= i_sample[7:0];
            end else begin
                log_mem[byte_addr_w] <= i_sample[7:0];
            end
        end
    end

    // read multiplexer over the register map and datalog
    always @* begin
        rd_byte = 8'h00;
        if (i_rd_addr[`ADDR_W-1:`LOG_ADDR_W] == `LOG_PAGE) begin
            rd_byte = log_mem[i_rd_addr[`LOG_ADDR_W-1:0]];
        end else if (i_rd_addr == `A_LIFE_CNT0) begin
            rd_byte = life_cnt_ff[7:0];
        end else if (i_rd_addr == `A_LIFE_CNT1) begin
            rd_byte = life_cnt_ff[15:8];
        end else if (i_rd_addr == `A_LIFE_CNT2) begin
            rd_byte = life_cnt_ff[23:16];
        end else if (i_rd_addr == `A_VARIANT) begin
            rd_byte = VARIANT_CODE;
        end else if (i_rd_addr == `A_PW_CTRL) begin
            rd_byte = pw_ctrl_ff;
        end else if (in_range(i_rd_addr, `A_READ_SECRET, `A_SECRET_END)) begin
            rd_byte = 8'h00;
        end else if (i_rd_addr == `A_MISSION_CTRL) begin
            rd_byte = mission_ctrl_ff;
        end else if (i_rd_addr == `A_GEN_STATUS) begin
            rd_byte = `GEN_STATUS_FIXED;
            rd_byte[`BIT_MISSION_RUN] = o_mission_running_flag;
        end
    end

    // registered read answer, only while a read has been granted
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            o_log_stopped <= 1'b0;
        end else if (i_ce) begin
            // a read that meets the locking edge is dropped as well
            o_rd_valid <= i_rd_en && rd_gate_ff &&
                nxt_state != ST_LOCK;
            o_rd_data <= (i_rd_en && rd_gate_ff && nxt_state != ST_LOCK) ?
                rd_byte : 8'h00;
            o_log_stopped <= log_full_w;
        end
    end
endmodule // password_gated_logger_memory
`default_nettype wire

// ---- verification/host_link_model.sv ----
// host master model: command byte, then the 64-bit password slot
`default_nettype none
module host_link_model (
    input wire logic i_clk,
    output logic o_cmd_valid,
    output logic [2:0] o_cmd,
    output logic o_pw_bit_valid,
    output logic o_pw_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle lines at time zero
    initial begin
        o_cmd_valid = 0;
        o_cmd = 0;
        o_pw_bit_valid = 0;
        o_pw_bit = 0;
    end
    // command, then password from the next cycle or after idle gaps when slow, bit 0 first
    task automatic send(input logic [2:0] c, input logic [63:0] pw,
                        input bit with_pw, input bit slow);
        @(posedge i_clk) #1;
        o_cmd_valid = 1;
        o_cmd = c;
        @(posedge i_clk) #1;
        o_cmd_valid = 0;
        o_cmd = ~c;
        for (int k = 0; with_pw && k < 64; k++) begin
            // slow host: idle gaps where the bit line keeps changing
            for (int g = 0; slow && g < 4 && $urandom_range(1); g++) begin
                o_pw_bit_valid = 0;
                o_pw_bit = ~o_pw_bit;
                @(posedge i_clk) #1;
            end
            o_pw_bit_valid = 1;
            o_pw_bit = pw[k];
            @(posedge i_clk) #1;
        end
        o_pw_bit_valid = 0;
        o_pw_bit = ~o_pw_bit;
    endtask
endmodule // host_link_model
`default_nettype wire

// ---- verification/password_gated_logger_memory_assertions.sv ----
// concurrent checks on the logger memory ports
`default_nettype none
`include "logger_mem_regs.vh"
module logger_mem_checker #(
    parameter [7:0] VARIANT_CODE = `VARIANT_CODE_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_bus_reset,
    input wire logic i_cmd_valid,
    input wire logic [2:0] i_cmd,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_granted,
    input wire logic o_refused,
    input wire logic o_exec_pulse,
    input wire logic [2:0] o_exec_cmd,
    input wire logic o_mission_running_flag
);
    logic [15:0] addr_ff; // address of the latest read request
    logic [2:0] last_ff; // latest executed command
    // remember read address and last executed command
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            addr_ff <= 16'h0000;
            last_ff <= 3'h0;
        end else begin
            if (i_rd_en) addr_ff <= i_rd_addr;
            if (o_exec_pulse) last_ff <= o_exec_cmd;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_exec_pulse; o_exec_pulse |=> !o_exec_pulse; endproperty
    a_exec_pulse: assert property (p_exec_pulse)
        else $error("exec pulse longer than one cycle");
    property p_free_cmd; i_cmd_valid && i_cmd >= 3'h6 && !o_refused |->
        ##[1:3] (o_exec_pulse && o_exec_cmd >= 3'h6); endproperty
    a_free_cmd: assert property (p_free_cmd)
        else $error("free command not executed");
    property p_lock_holds; o_refused && !i_bus_reset |=> o_refused;
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("lock dropped without bus reset");
    property p_lock_quiet; o_refused |->
        !o_exec_pulse && !o_granted && !o_rd_valid; endproperty
    a_lock_quiet: assert property (p_lock_quiet)
        else $error("activity while locked");
    property p_rd_cause; o_rd_valid |-> $past(i_rd_en) || $past(i_rd_en, 2);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read data without request");
    property p_secret_zero; o_rd_valid && addr_ff >= `A_READ_SECRET &&
        addr_ff <= `A_SECRET_END |-> o_rd_data == 8'h00; endproperty
    a_secret_zero: assert property (p_secret_zero)
        else $error("password byte readable");
    property p_variant; o_rd_valid && addr_ff == `A_VARIANT |->
        o_rd_data == VARIANT_CODE; endproperty
    a_variant: assert property (p_variant)
        else $error("variant byte wrong");
    property p_status; o_rd_valid && addr_ff == `A_GEN_STATUS |-> o_rd_data ==
        (`GEN_STATUS_FIXED | {6'h00, o_mission_running_flag, 1'b0}); endproperty
    a_status: assert property (p_status)
        else $error("status byte wrong");
    property p_flag_rise; $rose(o_mission_running_flag) |-> last_ff ==
        `CMD_START || (o_exec_pulse && o_exec_cmd == `CMD_START); endproperty
    a_flag_rise: assert property (p_flag_rise)
        else $error("mission flag set without start");
endmodule // logger_mem_checker
bind password_gated_logger_memory logger_mem_checker #(
    .VARIANT_CODE(VARIANT_CODE)
) logger_mem_checker_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus_reset(i_bus_reset),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_granted(o_granted),
    .o_refused(o_refused), .o_exec_pulse(o_exec_pulse),
    .o_exec_cmd(o_exec_cmd), .o_mission_running_flag(o_mission_running_flag)
);
`default_nettype wire

// ---- verification/password_gated_logger_memory_tb.sv ----
// self-checking bench of the password-gated logger memory
`default_nettype none
`include "logger_mem_regs.vh"
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module password_gated_logger_memory_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] VC = 8'h3C; // arbitrary variant value
    logic i_clk = 0, i_sys_rst = 1, i_bus_reset = 0, i_rd_en = 0;
    logic i_copy_en = 0, i_sample_valid = 0, i_sample_mission = 0;
    logic [15:0] i_rd_addr = 0, i_copy_addr = 0, i_sample = 0;
    logic [7:0] i_copy_data = 0, o_rd_data, d;
    logic i_cmd_valid, i_pw_bit_valid, i_pw_bit, o_rd_valid, o_granted;
    logic o_refused, o_exec_pulse, o_mission_running_flag, o_log_stopped;
    logic [2:0] i_cmd, o_exec_cmd;
    logic [63:0] rpw, fpw; // read and full-access passwords
    logic [23:0] life = 0; // expected lifetime count
    logic [15:0] s [0:8192]; // mission samples sent
    int failures = 0, num_checks = 0;
    int ix [4] = '{0, 1, 2, 4095};
    wire logic [2:0] ev = {o_rd_valid, o_refused, o_granted};
    password_gated_logger_memory #(
        .VARIANT_CODE(VC)
    ) password_gated_logger_memory_i (
        .i_clk, .i_sys_rst, .i_ce(1'b1), .i_bus_reset, .i_cmd_valid, .i_cmd,
        .i_pw_bit_valid, .i_pw_bit, .i_rd_en, .i_rd_addr, .i_copy_en,
        .i_copy_addr, .i_copy_data, .i_sample_valid, .i_sample_mission,
        .i_sample, .o_rd_data, .o_rd_valid, .o_granted, .o_refused,
        .o_exec_pulse, .o_exec_cmd, .o_mission_running_flag, .o_log_stopped
    );
    host_link_model host_link_model_i (
        .i_clk, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd),
        .o_pw_bit_valid(i_pw_bit_valid), .o_pw_bit(i_pw_bit)
    );
    // 200 MHz clock
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    // expected general status byte
    function automatic logic [7:0] stat(input logic f);
        return `GEN_STATUS_FIXED | {6'h00, f, 1'b0};
    endfunction
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk) #1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for granted, refused or read data
    task automatic await(input int w);
        for (int k = 0; k < 300; k++) begin
            if (ev[w] === 1'b1) return;
            tick();
        end
        failures++;
        $display("wrong value at %0t: no answer", $time);
        summarize();
    endtask
    // command via host; copy byte goes in the open cycle
    task automatic cmd(input logic [2:0] c, input logic [63:0] pw,
                       input bit ok);
        host_link_model_i.send(c, pw, c < 3'h6, 1'($urandom_range(1)));
        await(ok ? 0 : 1);
        if (ok) `CHK(o_exec_cmd, c)
        else `CHK({o_granted, o_exec_pulse}, 2'b00)
        i_copy_en = ok && c == `CMD_COPY_SP;
        tick();
        i_copy_en = 0;
    endtask
    task automatic cp(input logic [15:0] a, input logic [7:0] v);
        i_copy_addr = a;
        i_copy_data = v;
        cmd(`CMD_COPY_SP, fpw, 1);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        i_rd_addr = a;
        i_rd_en = 1;
        tick();
        i_rd_en = 0;
        await(2);
        q = o_rd_data;
        tick();
    endtask
    task automatic breset;
        i_bus_reset = 1;
        tick();
        i_bus_reset = 0;
        tick();
        `CHK(o_refused, 1'b0)
    endtask
    task automatic smp(input logic [15:0] v, input bit m);
        i_sample = v;
        i_sample_mission = m;
        i_sample_valid = 1;
        tick();
        i_sample_valid = 0;
        i_sample = ~v;
        tick();
        life++;
    endtask
    task automatic chk_life;
        for (int i = 0; i < 3; i++) begin
            rd(16'(`A_LIFE_CNT0 + i), d);
            `CHK(d, life[8*i +: 8])
        end
    endtask
    task automatic chk16(input int i, input logic [15:0] v);
        rd(16'(32'h2000 + 2 * i), d);
        `CHK(d, v[15:8])
        rd(16'(32'h2001 + 2 * i), d);
        `CHK(d, v[7:0])
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h77ec));
        rpw = {$urandom, $urandom};
        fpw = {$urandom, $urandom};
        tick(2);
        i_sys_rst = 0;
        cmd(`CMD_SP_RW, 0, 1);
        cmd(`CMD_FORCE_CONV, 0, 1);
        repeat (2 + $urandom_range(4)) smp(16'($urandom), 0);
        cmd(`CMD_RD_CRC, {$urandom, $urandom}, 1);
        chk_life();
        rd(`A_PW_CTRL, d);
        `CHK(d, `PW_CTRL_RESET)
        rd(`A_GEN_STATUS, d);
        `CHK(d, stat(0))
        $display("test defaults done");
        cp(`A_VARIANT, ~VC);
        cmd(`CMD_SP_RW, 0, 1);
        for (int i = 0; i < 16; i++) cp(16'(`A_READ_SECRET + i),
            i < 8 ? rpw[8*i +: 8] : fpw[8*(i-8) +: 8]);
        cp(`A_PW_CTRL, `PW_ENABLE_PATTERN);
        cmd(`CMD_SP_RW, 0, 1);
        cmd(`CMD_RD_CRC, rpw, 1);
        rd(`A_VARIANT, d);
        `CHK(d, VC)
        for (int i = 0; i < 16; i++) begin
            rd(16'(`A_READ_SECRET + i), d);
            `CHK(d, 8'h00)
        end
        $display("test setup done");
        cmd(`CMD_RD_CRC, ~rpw, 0);
        i_rd_en = 1;
        tick();
        `CHK(o_rd_valid, 1'b0)
        i_rd_en = 0;
        tick(3);
        `CHK(o_refused, 1'b1)
        breset();
        cmd(`CMD_RD_CRC, fpw, 1);
        cmd(`CMD_CLEAR, rpw, 0);
        breset();
        cmd(`CMD_SP_RW, 0, 1);
        $display("test passwords done");
        cp(`A_MISSION_CTRL, 8'h06);
        cmd(`CMD_CLEAR, fpw, 1);
        cmd(`CMD_START, fpw, 1);
        tick(2);
        `CHK(o_mission_running_flag, 1'b1)
        cp(`A_PW_CTRL, 8'h00);
        cp(`A_FULL_SECRET, ~fpw[7:0]);
        for (int i = 0; i < 4098; i++) begin
            s[i] = 16'($urandom);
            smp(s[i], 1);
        end
        `CHK(o_log_stopped, 1'b0)
        cmd(`CMD_RD_CRC, rpw, 1);
        rd(`A_GEN_STATUS, d);
        `CHK(d, stat(1))
        cmd(`CMD_STOP, fpw, 1);
        cmd(`CMD_RD_CRC, rpw, 1);
        rd(`A_PW_CTRL, d);
        `CHK(d, `PW_ENABLE_PATTERN)
        foreach (ix[k]) chk16(ix[k], s[ix[k] + (ix[k] < 2 ? 4096 : 0)]);
        $display("test rollover done");
        cp(`A_MISSION_CTRL, 8'h00);
        cmd(`CMD_CLEAR, fpw, 1);
        cmd(`CMD_START, fpw, 1);
        for (int i = 0; i < 8193; i++) begin
            s[i] = 16'($urandom);
            s[i][15:8] = s[i][7:0];
            smp(s[i], 1);
        end
        `CHK(o_log_stopped, 1'b1)
        cmd(`CMD_STOP, fpw, 1);
        cmd(`CMD_RD_CRC, rpw, 1);
        rd(16'h2000, d);
        `CHK(d, s[0][7:0])
        rd(16'h3FFF, d);
        `CHK(d, s[8191][7:0])
        chk_life();
        $display("test stop on full done");
        summarize();
    end
endmodule // password_gated_logger_memory_tb
`default_nettype wire
